// file: common/scic_cfg.svh
`ifndef SCIC_CFG_SVH
`define SCIC_CFG_SVH

// pointer, command and crc command fields of the command register
`define SCIC_PTR_LSB 0
`define SCIC_PTR_MSB 2
`define SCIC_CMD_LSB 3
`define SCIC_CMD_MSB 5
`define SCIC_CRC_LSB 6
`define SCIC_CRC_MSB 7

// immediate commands
`define SCIC_CMD_NULL 3'h0
`define SCIC_CMD_ABORT 3'h1
`define SCIC_CMD_RST_EXT 3'h2
`define SCIC_CMD_CHAN_RST 3'h3
`define SCIC_CMD_EN_NEXT 3'h4
`define SCIC_CMD_RST_TX 3'h5
`define SCIC_CMD_ERR_RST 3'h6
`define SCIC_CMD_EOS 3'h7

// crc commands
`define SCIC_CRC_NULL 2'h0
`define SCIC_CRC_RST_RX 2'h1
`define SCIC_CRC_RST_TX 2'h2
`define SCIC_CRC_RST_IDLE 2'h3

// interrupt and wait control register fields
`define SCIC_IW_EXT_EN 0
`define SCIC_IW_TX_EN 1
`define SCIC_IW_SAV 2
`define SCIC_IW_RXM_LSB 3
`define SCIC_IW_RXM_MSB 4
`define SCIC_IW_WSEL 5
`define SCIC_IW_WEN 7

// receive interrupt modes
`define SCIC_RXM_OFF 2'h0
`define SCIC_RXM_FIRST 2'h1
`define SCIC_RXM_ALL_PAR 2'h2
`define SCIC_RXM_ALL 2'h3

// register numbers and reset values
`define SCIC_REG_CMD 3'h0
`define SCIC_REG_IWC 3'h1
`define SCIC_PTR_RST 3'h0
`define SCIC_IWC_RST 8'h00

// abort length in transmit bits, and recovery after channel reset in clocks
`define SCIC_ABORT_BITS 4'hb
`define SCIC_RST_GUARD 3'h4

`endif

// file: common/scic_pkg.sv
package scic_pkg;
    typedef enum logic [1:0] {
        SCIC_TX_RUN,
        SCIC_TX_ABORT,
        SCIC_TX_IDLE
    } scic_tx_state_t;
endpackage

// file: design/scic_latch_bank.sv
`timescale 1ns/1ns
`default_nettype none
`include "scic_cfg.svh"

// sticky status latches; set wins over clear so no event is lost
module scic_latch_bank #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // control
    input wire logic [WIDTH-1:0] i_live,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_hold,
    input wire logic i_reopen,
    // state
    output logic [WIDTH-1:0] o_value
);
    logic [WIDTH-1:0] val_q;
    logic [WIDTH-1:0] val_d;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_comb begin
                if (i_set[g]) begin
                    val_d[g] = 1'b1;
                end else if (i_hold && !i_reopen) begin
                    val_d[g] = val_q[g];
                end else begin
                    val_d[g] = i_live[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            val_q <= '0;
        end else begin
            val_q <= val_d;
        end
    end

    assign o_value = val_q;
endmodule
`default_nettype wire

// file: design/scic_chan_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "scic_cfg.svh"

// Functional notes
// - pointer selects next control/status register
// - reset clears pointer to zero
// - nonzero pointer used once, then zero
// - pointer, command, crc act together
// - command 000 does nothing
// - 001 in sdlc mode flushes, sends ones, returns idle
// - ext status latches held; 010 clears
// - 011 resets channel; A resets chain
// - 100 rearms first character interrupt
// - 101 clears tx request until reload
// - 110 clears special, reopens error latches
// - chain held off; 111 on A releases
// - crc 01/10 reset checker/generator, mode value
// - crc 11 clears idle latch, crc sends
// - idle latch set after any reset
// - ext enable interrupts on status changes
// - tx enable interrupts on shift or idle
// - status affects vector selects modified vector
// - receive interrupt modes 00 to 11
// - overrun, end message are special; parity in mode 10 only
module scic_chan_ctrl #(
    parameter bit IS_CHAN_A = 1'b1
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // host control port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ctl_sel,
    input wire logic [7:0] i_wdata,
    // channel status
    input wire logic i_sdlc_mode,
    input wire logic i_sync_mode,
    input wire logic i_dma_mode,
    input wire logic [2:0] i_ext_live,
    input wire logic i_ext_event,
    input wire logic i_rx_char,
    input wire logic i_rx_parity_err,
    input wire logic i_rx_overrun,
    input wire logic i_rx_eom,
    input wire logic i_tx_to_shift,
    input wire logic i_tx_enter_idle,
    input wire logic i_tx_underrun,
    input wire logic i_tx_buf_full,
    input wire logic i_rx_buf_empty,
    input wire logic i_tx_bit_done,
    input wire logic i_chain_in_n,
    // register view
    output logic [2:0] o_reg_sel,
    output logic [7:0] o_iwc,
    output logic [2:0] o_ext_status,
    output logic [1:0] o_err_status,
    output logic o_idle_crc_latch,
    // interrupt and dma
    output logic o_int_req,
    output logic o_int_ext,
    output logic o_int_tx,
    output logic o_int_rx,
    output logic o_int_special,
    output logic o_vec_modified,
    output logic o_chain_out_n,
    output logic o_drq_tx,
    output logic o_drq_rx,
    // channel controls
    output logic o_chan_reset,
    output logic o_prio_reset,
    output logic o_tx_flush,
    output logic o_tx_abort_bit,
    output logic o_tx_send_crc,
    output logic o_rx_crc_clear,
    output logic o_tx_crc_clear,
    output logic o_crc_seed_ones,
    output logic o_wait_n
);
    logic [2:0] ptr_q, ptr_d;
    logic [7:0] iwc_q, iwc_d;
    logic ext_pend_q, ext_pend_d;
    logic tx_pend_q, tx_pend_d;
    logic rx_pend_q, rx_pend_d;
    logic sp_pend_q, sp_pend_d;
    logic first_arm_q, first_arm_d;
    logic idle_q, idle_d;
    logic in_svc_q, in_svc_d;
    logic drq_tx_q, drq_tx_d;
    logic drq_rx_q, drq_rx_d;
    logic rst_pulse_q, rst_pulse_d;
    logic prio_q, prio_d;
    logic flush_q, flush_d;
    logic rcrc_q, rcrc_d;
    logic tcrc_q, tcrc_d;
    logic crc_send_q, crc_send_d;
    logic wait_n_q, wait_n_d;
    logic req_q, req_d;
    logic vec_q, vec_d;
    scic_pkg::scic_tx_state_t tx_st_q, tx_st_d;
    logic [3:0] abort_cnt_q, abort_cnt_d;
    logic abort_bit_q, abort_bit_d;
    logic chain_s1_q, chain_s2_q, chain_s3_q;
    logic chain_ok_q, chain_ok_d;
    logic [2:0] ext_lat;
    logic [1:0] err_lat;
    logic cmd_wr, iwc_wr, ctl_acc, soft_rst, rst_all;
    logic [2:0] cmd;
    logic [1:0] crc_cmd, rx_mode;
    logic par_special, rx_int_ev, sp_ev;
    logic seed_q;

    // a control write with pointer zero lands in the command register
    assign ctl_acc = i_ctl_sel && (i_wr || i_rd);
    assign cmd_wr = i_ctl_sel && i_wr && (ptr_q == `SCIC_REG_CMD);
    assign iwc_wr = i_ctl_sel && i_wr && (ptr_q == `SCIC_REG_IWC);
    assign cmd = i_wdata[`SCIC_CMD_MSB:`SCIC_CMD_LSB];
    assign crc_cmd = i_wdata[`SCIC_CRC_MSB:`SCIC_CRC_LSB];
    assign soft_rst = cmd_wr && (cmd == `SCIC_CMD_CHAN_RST);
    assign rst_all = i_reset || soft_rst;
    assign rx_mode = iwc_q[`SCIC_IW_RXM_MSB:`SCIC_IW_RXM_LSB];
    assign par_special = (rx_mode == `SCIC_RXM_ALL_PAR) && i_rx_parity_err;
    assign sp_ev = i_rx_char && (i_rx_overrun || par_special || i_rx_eom);

    // error latches reopen on error reset; parity sticks only when special
    scic_latch_bank #(.WIDTH(2)) u_err (
        .i_mclk(i_mclk),
        .i_reset(rst_all),
        .i_live(2'h0),
        .i_set({i_rx_overrun && i_rx_char, par_special && i_rx_char}),
        .i_hold(1'b1),
        .i_reopen(cmd_wr && (cmd == `SCIC_CMD_ERR_RST)),
        .o_value(err_lat)
    );

    // condition bits freeze while a change is flagged so short pulses survive
    scic_latch_bank #(.WIDTH(3)) u_ext (
        .i_mclk(i_mclk),
        .i_reset(rst_all),
        .i_live(i_ext_live),
        .i_set(3'h0),
        .i_hold(ext_pend_q),
        .i_reopen(cmd_wr && (cmd == `SCIC_CMD_RST_EXT)),
        .o_value(ext_lat)
    );

    always_comb begin
        ptr_d = ptr_q;
        iwc_d = iwc_q;
        ext_pend_d = ext_pend_q;
        tx_pend_d = tx_pend_q;
        rx_pend_d = rx_pend_q;
        sp_pend_d = sp_pend_q;
        first_arm_d = first_arm_q;
        idle_d = idle_q;
        in_svc_d = in_svc_q;
        drq_tx_d = drq_tx_q;
        drq_rx_d = drq_rx_q;
        rst_pulse_d = soft_rst;
        prio_d = soft_rst && IS_CHAN_A;
        flush_d = 1'b0;
        rcrc_d = 1'b0;
        tcrc_d = 1'b0;
        crc_send_d = 1'b0;
        rx_int_ev = 1'b0;
        // clears come first so a same-cycle event wins
        if (cmd_wr) begin
            case (cmd)
                `SCIC_CMD_NULL: begin
                end
                `SCIC_CMD_ABORT: flush_d = i_sdlc_mode;
                `SCIC_CMD_RST_EXT: ext_pend_d = 1'b0;
                `SCIC_CMD_EN_NEXT: first_arm_d = 1'b1;
                `SCIC_CMD_RST_TX: begin
                    tx_pend_d = 1'b0;
                    drq_tx_d = 1'b0;
                end
                `SCIC_CMD_ERR_RST: sp_pend_d = 1'b0;
                `SCIC_CMD_EOS: begin
                    if (IS_CHAN_A) begin
                        in_svc_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            case (crc_cmd)
                `SCIC_CRC_NULL: begin
                end
                `SCIC_CRC_RST_RX: rcrc_d = 1'b1;
                `SCIC_CRC_RST_TX: tcrc_d = 1'b1;
                `SCIC_CRC_RST_IDLE: idle_d = 1'b0;
                default: begin
                end
            endcase
        end
        if (iwc_wr) begin
            iwc_d = i_wdata;
        end
        // pointer: set from the command write, else dropped after one use
        if (cmd_wr) begin
            ptr_d = i_wdata[`SCIC_PTR_MSB:`SCIC_PTR_LSB];
        end else if (ctl_acc) begin
            ptr_d = `SCIC_PTR_RST;
        end
        // underrun with the latch clear sends crc once, then idles
        if (i_tx_underrun && !idle_q) begin
            crc_send_d = 1'b1;
            idle_d = 1'b1;
        end
        if ((i_ext_event || (i_tx_underrun && !idle_q)) && iwc_q[`SCIC_IW_EXT_EN]) begin
            ext_pend_d = 1'b1;
        end
        if ((i_tx_to_shift || i_tx_enter_idle) && iwc_q[`SCIC_IW_TX_EN]) begin
            tx_pend_d = 1'b1;
        end
        if ((i_tx_to_shift || i_tx_enter_idle) && i_dma_mode) begin
            drq_tx_d = 1'b1;
        end
        if (i_rx_char) begin
            case (rx_mode)
                `SCIC_RXM_OFF: rx_int_ev = 1'b0;
                `SCIC_RXM_FIRST: begin
                    rx_int_ev = first_arm_q;
                    first_arm_d = 1'b0;
                end
                `SCIC_RXM_ALL_PAR: rx_int_ev = 1'b1;
                `SCIC_RXM_ALL: rx_int_ev = 1'b1;
                default: rx_int_ev = 1'b0;
            endcase
            if (rx_mode != `SCIC_RXM_OFF && i_dma_mode) begin
                drq_rx_d = 1'b1;
            end
        end else if (i_rd && !i_ctl_sel) begin
            drq_rx_d = 1'b0;
        end
        // data read clears first so a same-cycle character is kept
        if (i_rd && !i_ctl_sel) begin
            rx_pend_d = 1'b0;
        end
        if (rx_int_ev && sp_ev) begin
            sp_pend_d = 1'b1;
        end else if (rx_int_ev) begin
            rx_pend_d = 1'b1;
        end
        // a request issued with the chain open locks out lower ones
        if (req_q && chain_ok_q) begin
            in_svc_d = 1'b1;
        end
    end

    // abort bit counter: fixed count inside the 8 to 13 window
    always_comb begin
        tx_st_d = tx_st_q;
        abort_cnt_d = abort_cnt_q;
        abort_bit_d = 1'b0;
        case (tx_st_q)
            scic_pkg::SCIC_TX_RUN: begin
                if (flush_q) begin
                    tx_st_d = scic_pkg::SCIC_TX_ABORT;
                    abort_cnt_d = `SCIC_ABORT_BITS;
                end
            end
            scic_pkg::SCIC_TX_ABORT: begin
                abort_bit_d = 1'b1;
                if (i_tx_bit_done) begin
                    abort_cnt_d = abort_cnt_q - 4'h1;
                    if (abort_cnt_q == 4'h1) begin
                        tx_st_d = scic_pkg::SCIC_TX_IDLE;
                        abort_bit_d = 1'b0;
                    end
                end
            end
            scic_pkg::SCIC_TX_IDLE: tx_st_d = scic_pkg::SCIC_TX_RUN;
            default: tx_st_d = scic_pkg::SCIC_TX_RUN;
        endcase
    end

    // interrupt request, vector and wait outputs
    always_comb begin
        chain_ok_d = chain_s2_q && chain_s3_q ? 1'b0 : (!chain_s2_q && !chain_s3_q ? 1'b1
            : chain_ok_q);
        req_d = (ext_pend_q || tx_pend_q || rx_pend_q || sp_pend_q) && chain_ok_q
            && !in_svc_q;
        vec_d = iwc_q[`SCIC_IW_SAV];
        wait_n_d = 1'b1;
        if (iwc_q[`SCIC_IW_WEN]) begin
            if (!iwc_q[`SCIC_IW_WSEL] && i_wr && !i_ctl_sel && i_tx_buf_full) begin
                wait_n_d = 1'b0;
            end
            if (iwc_q[`SCIC_IW_WSEL] && i_rd && !i_ctl_sel && i_rx_buf_empty) begin
                wait_n_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        chain_s1_q <= i_chain_in_n;
        chain_s2_q <= chain_s1_q;
        chain_s3_q <= chain_s2_q;
        rst_pulse_q <= rst_pulse_d;
        prio_q <= prio_d;
        seed_q <= i_sdlc_mode && !i_sync_mode;
        if (rst_all) begin
            ptr_q <= `SCIC_PTR_RST;
            iwc_q <= `SCIC_IWC_RST;
            ext_pend_q <= 1'b0;
            tx_pend_q <= 1'b0;
            rx_pend_q <= 1'b0;
            sp_pend_q <= 1'b0;
            first_arm_q <= 1'b1;
            idle_q <= 1'b1;
            drq_tx_q <= 1'b0;
            drq_rx_q <= 1'b0;
            flush_q <= 1'b0;
            rcrc_q <= 1'b0;
            tcrc_q <= 1'b0;
            crc_send_q <= 1'b0;
            wait_n_q <= 1'b1;
            req_q <= 1'b0;
            vec_q <= 1'b0;
            tx_st_q <= scic_pkg::SCIC_TX_RUN;
            abort_cnt_q <= 4'h0;
            abort_bit_q <= 1'b0;
            chain_ok_q <= 1'b0;
        end else begin
            ptr_q <= ptr_d;
            iwc_q <= iwc_d;
            ext_pend_q <= ext_pend_d;
            tx_pend_q <= tx_pend_d;
            rx_pend_q <= rx_pend_d;
            sp_pend_q <= sp_pend_d;
            first_arm_q <= first_arm_d;
            idle_q <= idle_d;
            drq_tx_q <= drq_tx_d;
            drq_rx_q <= drq_rx_d;
            flush_q <= flush_d;
            rcrc_q <= rcrc_d;
            tcrc_q <= tcrc_d;
            crc_send_q <= crc_send_d;
            wait_n_q <= wait_n_d;
            req_q <= req_d;
            vec_q <= vec_d;
            tx_st_q <= tx_st_d;
            abort_cnt_q <= abort_cnt_d;
            abort_bit_q <= abort_bit_d;
            chain_ok_q <= chain_ok_d;
        end
        // the shared chain survives a channel B reset
        if (i_reset || (soft_rst && IS_CHAN_A)) begin
            in_svc_q <= 1'b0;
        end else begin
            in_svc_q <= in_svc_d;
        end
    end

    assign o_reg_sel = ptr_q;
    assign o_iwc = iwc_q;
    assign o_ext_status = ext_lat;
    assign o_err_status = err_lat;
    assign o_idle_crc_latch = idle_q;
    assign o_int_req = req_q;
    assign o_int_ext = ext_pend_q;
    assign o_int_tx = tx_pend_q;
    assign o_int_rx = rx_pend_q;
    assign o_int_special = sp_pend_q;
    assign o_vec_modified = vec_q;
    assign o_chain_out_n = in_svc_q;
    assign o_drq_tx = drq_tx_q;
    assign o_drq_rx = drq_rx_q;
    assign o_chan_reset = rst_pulse_q;
    assign o_prio_reset = prio_q;
    assign o_tx_flush = flush_q;
    assign o_tx_abort_bit = abort_bit_q;
    assign o_tx_send_crc = crc_send_q;
    assign o_rx_crc_clear = rcrc_q;
    assign o_tx_crc_clear = tcrc_q;
    assign o_crc_seed_ones = seed_q;
    assign o_wait_n = wait_n_q;
endmodule
`default_nettype wire

// file: tb/scic_chan_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module scic_chan_ctrl_sva #(
    parameter bit IS_CHAN_A = 1'b1
) (
    // clock, reset and host port
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ctl_sel,
    input wire logic [7:0] i_wdata,
    // channel status
    input wire logic i_sdlc_mode,
    input wire logic i_sync_mode,
    input wire logic i_tx_underrun,
    input wire logic i_tx_buf_full,
    // design outputs
    input wire logic [2:0] o_reg_sel,
    input wire logic [7:0] o_iwc,
    input wire logic [2:0] o_ext_status,
    input wire logic o_idle_crc_latch,
    input wire logic o_int_ext,
    input wire logic o_chan_reset,
    input wire logic o_prio_reset,
    input wire logic o_tx_flush,
    input wire logic o_tx_abort_bit,
    input wire logic o_rx_crc_clear,
    input wire logic o_tx_crc_clear,
    input wire logic o_crc_seed_ones,
    input wire logic o_wait_n
);
    logic [7:0] wd_q;
    logic cmd_wr;
    assign cmd_wr = i_wr && i_ctl_sel && o_reg_sel == 3'h0;
    // byte of the write edge, for checks one cycle later
    always_ff @(posedge i_mclk) begin
        wd_q <= i_wdata;
    end
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);
    sequence s_cmd(logic [2:0] c);
        cmd_wr && i_wdata[5:3] == c;
    endsequence
    sequence s_abort;
        o_tx_flush ##2 o_tx_abort_bit;
    endsequence
    sequence s_reset_state;
        o_reg_sel == 3'h0 && o_idle_crc_latch && o_iwc == 8'h00;
    endsequence
    ptr_load_a:
        assert property (cmd_wr && i_wdata[5:3] != 3'h3 |=> o_reg_sel == wd_q[2:0])
        else $error("pointer not loaded");
    ptr_return_a:
        assert property (o_reg_sel != 3'h0 && i_ctl_sel && (i_wr || i_rd) |=> o_reg_sel == 3'h0)
        else $error("pointer not returned to zero");
    reset_state_a:
        assert property (disable iff (1'b0) i_reset |=> s_reset_state)
        else $error("wrong state after reset");
    iwc_load_a:
        assert property (o_reg_sel == 3'h1 && i_wr && i_ctl_sel |=> o_iwc == wd_q)
        else $error("interrupt control byte not loaded");
    null_cmd_a:
        assert property (cmd_wr && i_wdata[7:3] == 5'h00 |=>
            !(o_tx_flush || o_chan_reset || o_rx_crc_clear || o_tx_crc_clear))
        else $error("null command had an effect");
    abort_seq_a:
        assert property (s_cmd(3'h1) ##0 i_sdlc_mode |=> s_abort)
        else $error("abort not started");
    ext_hold_a:
        assert property (o_int_ext && !o_chan_reset && !(i_wr && i_ctl_sel) |=>
            $stable(o_ext_status))
        else $error("status moved while latched");
    chan_rst_a:
        assert property (s_cmd(3'h3) |=> o_chan_reset && o_prio_reset == IS_CHAN_A
            ##[1:2] s_reset_state)
        else $error("channel reset incomplete");
    crc_cmd_a:
        assert property (cmd_wr && i_wdata[7:6] != 2'h0 && i_wdata[5:3] != 3'h3 |=>
            o_rx_crc_clear == (wd_q[7:6] == 2'h1) && o_tx_crc_clear == (wd_q[7:6] == 2'h2))
        else $error("wrong crc clear");
    seed_mode_a:
        assert property (o_crc_seed_ones == ($past(i_sdlc_mode) && !$past(i_sync_mode)))
        else $error("wrong crc seed");
    idle_clr_a:
        assert property (cmd_wr && i_wdata[7:3] == 5'h18 && !i_tx_underrun |=> !o_idle_crc_latch)
        else $error("idle latch not cleared");
    wait_tx_a:
        assert property (i_wr && !i_ctl_sel && i_tx_buf_full && o_iwc[7] && !o_iwc[5] |=>
            !o_wait_n)
        else $error("no wait on full transmit buffer");
    wait_rel_a:
        assert property (!i_wr && !i_rd |=> o_wait_n)
        else $error("wait held without a strobe");
endmodule
bind scic_chan_ctrl scic_chan_ctrl_sva #(.IS_CHAN_A(IS_CHAN_A)) chk_u (
    .i_mclk, .i_reset, .i_wr, .i_rd, .i_ctl_sel, .i_wdata, .i_sdlc_mode, .i_sync_mode,
    .i_tx_underrun, .i_tx_buf_full, .o_reg_sel, .o_iwc, .o_ext_status, .o_idle_crc_latch,
    .o_int_ext, .o_chan_reset, .o_prio_reset, .o_tx_flush, .o_tx_abort_bit, .o_rx_crc_clear,
    .o_tx_crc_clear, .o_crc_seed_ones, .o_wait_n);
`default_nettype wire

// file: tb/scic_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the control port; one-clock strobes, no wait stretching
module scic_host_model (
    // clock
    input wire logic i_mclk,
    // host bus
    output logic o_wr,
    output logic o_rd,
    output logic o_ctl_sel,
    output logic [7:0] o_wdata,
    // chain enable from higher priority
    output logic o_chain_in_n
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_ctl_sel = 1'b0;
        o_wdata = 8'h00;
        o_chain_in_n = 1'b0;
    end
    // released bus shows the inverse so stale data never passes
    task automatic access(input logic wr, input logic ctl, input logic [7:0] d);
        @(negedge i_mclk);
        o_wr = wr;
        o_rd = !wr;
        o_ctl_sel = ctl;
        o_wdata = d;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = ~d;
    endtask
    task automatic ctl_wr(input logic [7:0] d);
        access(1'b1, 1'b1, d);
    endtask
    task automatic set_iwc(input logic [7:0] d);
        ctl_wr(8'h01);
        ctl_wr(d);
    endtask
    task automatic chan_reset();
        ctl_wr(8'h18);
        repeat (4) @(negedge i_mclk);
    endtask
    // end of service goes to channel a only
    task automatic end_service();
        ctl_wr(8'h38);
    endtask
    // higher priority device holds the chain
    task automatic hold_chain(input logic v);
        o_chain_in_n = v;
    endtask
endmodule
`default_nettype wire

// file: tb/serial_command_interrupt_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module serial_command_interrupt_ctrl_tb;
    logic i_mclk, i_reset, i_wr, i_rd, i_ctl_sel, i_chain_in_n, i_dma_mode;
    logic [7:0] i_wdata, o_iwc;
    logic i_sdlc_mode, i_sync_mode, i_rx_parity_err, i_rx_overrun, i_rx_eom;
    logic i_tx_buf_full, i_rx_buf_empty;
    logic [2:0] i_ext_live, o_reg_sel, o_ext_status;
    logic [1:0] o_err_status;
    logic [5:0] ev;
    logic i_ext_event, i_rx_char, i_tx_to_shift, i_tx_enter_idle, i_tx_underrun, i_tx_bit_done;
    logic o_idle_crc_latch, o_int_req, o_int_ext, o_int_tx, o_int_rx, o_int_special;
    logic o_vec_modified, o_chain_out_n, o_drq_tx, o_drq_rx, o_chan_reset, o_prio_reset;
    logic o_tx_flush, o_tx_abort_bit, o_tx_send_crc, o_rx_crc_clear, o_tx_crc_clear;
    logic o_crc_seed_ones, o_wait_n;
    logic [6:0] pv;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int pc [7];
    assign {i_tx_bit_done, i_ext_event, i_rx_char, i_tx_to_shift, i_tx_enter_idle,
        i_tx_underrun} = ev;
    // pulse and wait-low cycle counters; exact latency left to the checker
    assign pv = {!o_wait_n, o_tx_send_crc, o_tx_crc_clear, o_rx_crc_clear, o_prio_reset,
        o_chan_reset, o_tx_flush};
    scic_host_model host_u (.i_mclk, .o_wr(i_wr), .o_rd(i_rd), .o_ctl_sel(i_ctl_sel),
        .o_wdata(i_wdata), .o_chain_in_n(i_chain_in_n));
    scic_chan_ctrl #(.IS_CHAN_A(1'b1)) dut_u (.i_mclk, .i_reset, .i_wr, .i_rd, .i_ctl_sel,
        .i_wdata, .i_sdlc_mode, .i_sync_mode, .i_dma_mode, .i_ext_live, .i_ext_event,
        .i_rx_char, .i_rx_parity_err, .i_rx_overrun, .i_rx_eom, .i_tx_to_shift,
        .i_tx_enter_idle, .i_tx_underrun, .i_tx_buf_full, .i_rx_buf_empty, .i_tx_bit_done,
        .i_chain_in_n, .o_reg_sel, .o_iwc, .o_ext_status, .o_err_status, .o_idle_crc_latch,
        .o_int_req, .o_int_ext, .o_int_tx, .o_int_rx, .o_int_special, .o_vec_modified,
        .o_chain_out_n, .o_drq_tx, .o_drq_rx, .o_chan_reset, .o_prio_reset, .o_tx_flush,
        .o_tx_abort_bit, .o_tx_send_crc, .o_rx_crc_clear, .o_tx_crc_clear, .o_crc_seed_ones,
        .o_wait_n);
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic results();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        for (int k = 0; k < 7; k++) begin
            if (pv[k] === 1'b1) pc[k]++;
        end
        if (cycles == 5000) begin
            error_cnt++;
            results();
        end
    end
    task automatic clr();
        foreach (pc[k]) pc[k] = 0;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic pulse(input int k);
        @(negedge i_mclk);
        ev[k] = 1'b1;
        @(negedge i_mclk);
        ev[k] = 1'b0;
    endtask
    initial begin
        {ev, i_ext_live, i_dma_mode, i_rx_eom, i_rx_overrun, i_rx_parity_err} = '0;
        {i_sdlc_mode, i_sync_mode, i_tx_buf_full, i_rx_buf_empty} = '0;
        i_reset = 1'b1;
        clr();
        ticks(12);
        i_reset = 1'b0;
        `CHK(o_reg_sel, 3'h0)
        `CHK(o_idle_crc_latch, 1'b1)
        host_u.ctl_wr(8'h05);
        `CHK(o_reg_sel, 3'h5)
        host_u.access(1'b0, 1'b1, 8'h00);
        `CHK(o_reg_sel, 3'h0)
        host_u.set_iwc(8'h07);
        `CHK(o_iwc, 8'h07)
        ticks(1);
        `CHK(o_vec_modified, 1'b1)
        for (int c = 0; c < 4; c++) begin
            clr();
            host_u.ctl_wr({c[1:0], 6'h02});
            ticks(2);
            `CHK(o_reg_sel, 3'h2)
            `CHK(pc[3], int'(c == 1))
            `CHK(pc[4], int'(c == 2))
            `CHK(pc[0] + pc[1], 0)
            `CHK(o_idle_crc_latch, c != 3)
            host_u.access(1'b0, 1'b1, 8'h00);
        end
        pulse(0);
        ticks(4);
        `CHK(pc[5], 1)
        `CHK(o_idle_crc_latch, 1'b1)
        `CHK(o_int_ext, 1'b1)
        `CHK(o_chain_out_n, 1'b1)
        host_u.ctl_wr(8'h10);
        host_u.end_service();
        ticks(3);
        `CHK(o_int_ext, 1'b0)
        `CHK(o_chain_out_n, 1'b0)
        i_ext_live = 3'h5;
        pulse(4);
        i_ext_live = 3'h2;
        ticks(3);
        `CHK(o_ext_status, 3'h5)
        host_u.ctl_wr(8'h10);
        ticks(3);
        `CHK(o_ext_status, 3'h2)
        host_u.end_service();
        i_dma_mode = 1'b1;
        pulse(2);
        ticks(3);
        `CHK(o_int_tx, 1'b1)
        `CHK(o_drq_tx, 1'b1)
        host_u.ctl_wr(8'h28);
        ticks(3);
        `CHK(o_int_tx, 1'b0)
        `CHK(o_drq_tx, 1'b0)
        pulse(1);
        ticks(3);
        `CHK(o_int_tx, 1'b1)
        host_u.ctl_wr(8'h28);
        host_u.end_service();
        host_u.set_iwc(8'h08);
        for (int n = 0; n < 3; n++) begin
            if (n == 2) host_u.ctl_wr(8'h20);
            pulse(3);
            ticks(3);
            `CHK(o_int_rx, n != 1)
            `CHK(o_drq_rx, 1'b1)
            host_u.access(1'b0, 1'b0, 8'h00);
            host_u.end_service();
        end
        i_rx_parity_err = 1'b1;
        for (int m = 0; m < 4; m++) begin
            host_u.set_iwc({3'h0, m[1:0], 3'h0});
            pulse(3);
            ticks(3);
            `CHK(o_int_special, m == 2)
            `CHK(o_int_rx, m == 3)
            `CHK(o_err_status[0], m == 2)
            host_u.ctl_wr(8'h30);
            ticks(2);
            `CHK(o_int_special, 1'b0)
            host_u.access(1'b0, 1'b0, 8'h00);
            host_u.end_service();
        end
        {i_rx_overrun, i_rx_eom} = 2'h3;
        pulse(3);
        ticks(3);
        `CHK(o_int_special, 1'b1)
        `CHK(o_err_status, 2'h2)
        {i_rx_overrun, i_rx_eom} = 2'h0;
        host_u.ctl_wr(8'h30);
        host_u.end_service();
        host_u.hold_chain(1'b1);
        ticks(5);
        pulse(3);
        ticks(4);
        `CHK(o_int_req, 1'b0)
        host_u.hold_chain(1'b0);
        ticks(6);
        `CHK(o_int_req, 1'b1)
        `CHK(o_chain_out_n, 1'b1)
        host_u.access(1'b0, 1'b0, 8'h00);
        host_u.end_service();
        i_sdlc_mode = 1'b1;
        ticks(1);
        `CHK(o_crc_seed_ones, 1'b1)
        clr();
        host_u.ctl_wr(8'h08);
        ticks(2);
        `CHK(pc[0], 1)
        `CHK(o_tx_abort_bit, 1'b1)
        repeat (10) pulse(5);
        ticks(1);
        `CHK(o_tx_abort_bit, 1'b1)
        pulse(5);
        ticks(2);
        `CHK(o_tx_abort_bit, 1'b0)
        i_sync_mode = 1'b1;
        ticks(1);
        `CHK(o_crc_seed_ones, 1'b0)
        host_u.set_iwc(8'h80);
        i_tx_buf_full = 1'b1;
        clr();
        host_u.access(1'b1, 1'b0, 8'h55);
        ticks(2);
        `CHK(pc[6], 1)
        host_u.set_iwc(8'ha0);
        for (int w = 1; w >= 0; w--) begin
            i_rx_buf_empty = w[0];
            clr();
            host_u.access(1'b0, 1'b0, 8'h00);
            ticks(2);
            `CHK(pc[6], w)
        end
        host_u.ctl_wr(8'hc0);
        clr();
        host_u.chan_reset();
        `CHK(pc[1] + pc[2], 2)
        `CHK(o_iwc, 8'h00)
        `CHK(o_idle_crc_latch, 1'b1)
        results();
    end
endmodule
`default_nettype wire
